//--- bench/sarc_analog_model.sv
// behavioural sample-hold, ladder and comparator
`timescale 1ns/10ps
module sarc_analog_model (
  input  wire logic [2:0] channel_i,
  input  wire logic       enable_i,
  input  wire logic [9:0] dac_code_i,
  output logic            comp_o
);
  logic [9:0] level;

  // each input level equals its code and the comparator passes codes up to it, so the result equals the code
  assign level  = enable_i ? {channel_i, 7'h55} : 10'h000;
  assign comp_o = dac_code_i <= level;
endmodule

//--- bench/sarc_regs_asserts.sv
// bus, timing and standby checks on the converter control block ports
`timescale 1ns/10ps
module sarc_regs_asserts #(
  parameter int RES_W = 10
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic             standby_i,
  input wire logic             analog_input_enable_o,
  input wire logic             ladder_connect_o,
  input wire logic             sample_o,
  input wire logic [RES_W-1:0] dac_code_o,
  input wire logic             conversion_done_interrupt_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answer: one cycle after the request, one cycle long
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  // done pulse is one cycle and done pulses are at least nine cycles apart
  a_irq_spacing: assert property (
    conversion_done_interrupt_o |=> !conversion_done_interrupt_o [*8])
    else $error("done pulse too long or too close");
  // idle converter drives no trial code
  a_idle_dac_zero: assert property (!ladder_connect_o |-> dac_code_o == '0)
    else $error("trial code while idle");
  a_sample_ladder: assert property (sample_o |-> ladder_connect_o)
    else $error("sampling without ladder");
  // sampling phase holds for at least eight cycles
  a_sample_length: assert property ($rose(sample_o) |-> sample_o [*8])
    else $error("sampling phase too short");
  // standby resets the controls and stops the converter
  a_standby_clear: assert property (
    standby_i [*2] |-> !ladder_connect_o && !analog_input_enable_o)
    else $error("standby did not clear");
endmodule

bind sarc_regs sarc_regs_asserts #(.RES_W(RES_W)) sarc_regs_asserts_i (
  .clk_i,
  .rst_i,
  .wb_cyc_i,
  .wb_stb_i,
  .wb_ack_o,
  .standby_i,
  .analog_input_enable_o,
  .ladder_connect_o,
  .sample_o,
  .dac_code_o,
  .conversion_done_interrupt_o
);

//--- bench/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] A1 = sarc_pkg::ADR_CTRL_ONE;
  localparam logic [7:0] A2 = sarc_pkg::ADR_CTRL_TWO;
  localparam logic [7:0] AL = sarc_pkg::ADR_RESULT_LOW;
  localparam logic [7:0] AH = sarc_pkg::ADR_RESULT_HIGH;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        stby = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  lanes = 4'hF;
  logic [31:0] rdat;
  logic        ack;
  logic        comp;
  logic        chv;
  logic        aie;
  logic        lad;
  logic        smp;
  logic        irq;
  logic [2:0]  ch;
  logic [9:0]  dac;
  logic [7:0]  q;
  int          bad_count = 0;
  int          comparisons = 0;
  int          lad_cnt = 0;
  int          irq_cnt = 0;
  int          nt[8] = '{39, 39, 78, 156, 312, 624, 1248, 39};

  always #2.5 clk_i = ~clk_i;

  // busy cycles seen on the ladder and done pulses
  always @(posedge clk_i) begin
    if (lad) lad_cnt <= lad_cnt + 1;
    if (irq) irq_cnt <= irq_cnt + 1;
  end

  sarc_regs sarc_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .standby_i(stby), .comp_i(comp), .channel_o(ch), .channel_valid_o(chv),
    .analog_input_enable_o(aie), .ladder_connect_o(lad), .sample_o(smp),
    .dac_code_o(dac), .conversion_done_interrupt_o(irq)
  );

  sarc_analog_model sarc_analog_model_i (
    .channel_i(ch), .enable_i(aie), .dac_code_i(dac), .comp_o(comp)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one classic bus cycle, held until ack is sampled
  task automatic bus(input int w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= (w != 0);
    adr <= a;
    sel <= lanes;
    wdat <= {24'h0, d};
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat[7:0];
    chk(16'(n < 20), 16'h1, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wait_irq();
    int c0;
    c0 = irq_cnt;
    for (int n = 0; n < 1400 && irq_cnt == c0; n++) @(posedge clk_i);
  endtask

  task automatic t_reset();
    bus(0, A1, 8'h00); chk(q, 8'h10, "ctrl one reset");
    bus(0, A2, 8'h00); chk(q & 8'h3F, 8'h10, "ctrl two reset");
    bus(0, AH, 8'h00); chk(q, 8'h00, "high reset");
    bus(0, AL, 8'h00); chk(q & 8'hF0, 8'h00, "low reset");
    bus(0, 8'h00, 8'h00); chk(q, 8'h00, "unmapped read");
    chk(aie, 1'b0, "inputs off");
  endtask

  // single conversion with each time code on its own channel
  task automatic t_conv(input int i);
    logic [2:0] c;
    logic [9:0] v;
    int n0;
    c = 3'(7 - i);
    v = {c, 7'h55};
    bus(1, A2, {4'h1, 3'(i), 1'b0});
    bus(1, A1, {5'h04, c});
    // register outputs settle after the ack edge
    @(posedge clk_i);
    chk(ch, c, "channel");
    chk({aie, chv}, 2'b11, "inputs on");
    n0 = lad_cnt;
    bus(1, A1, {5'h14, c});
    bus(0, AL, 8'h00); chk(q & 8'h30, 8'h10, "busy");
    bus(0, A1, 8'h00); chk(q, {5'h04, c}, "start cleared");
    wait_irq();
    chk(16'(lad_cnt - n0), 16'(nt[i]), "length");
    bus(0, AL, 8'h00); chk(q & 8'hF0, {v[1:0], 6'h20}, "low");
    bus(0, AH, 8'h00); chk(q, v[9:2], "high");
    bus(0, AL, 8'h00); chk(q & 8'h20, 8'h00, "flag cleared");
  endtask

  task automatic t_ladder();
    bus(1, A2, 8'h30);
    @(posedge clk_i);
    chk(lad, 1'b1, "ladder always");
    bus(1, A2, 8'h10);
    bus(1, A1, 8'h28);
    @(posedge clk_i);
    chk({lad, chv}, 2'b00, "ladder off, bad channel");
    // write without the low byte lane is ignored
    lanes = 4'hE;
    bus(1, A2, 8'h30);
    lanes = 4'hF;
    @(posedge clk_i);
    chk(lad, 1'b0, "lane zero write ignored");
  endtask

  task automatic t_repeat();
    int c0;
    bus(1, A1, 8'h62);
    c0 = irq_cnt;
    bus(1, A1, 8'hE2);
    wait_irq();
    wait_irq();
    chk(16'(irq_cnt - c0), 16'h2, "repeat");
    repeat (15) @(posedge clk_i);
    bus(1, A1, 8'h02);
    c0 = irq_cnt;
    repeat (100) @(posedge clk_i);
    chk({15'(irq_cnt - c0), lad}, 16'h0, "abort");
  endtask

  // start with disabled and reserved modes does nothing
  task automatic t_modes();
    logic [7:0] m[2] = '{8'h81, 8'hC1};
    int c0;
    for (int k = 0; k < 2; k++) begin
      c0 = irq_cnt;
      bus(1, A1, m[k]);
      repeat (60) @(posedge clk_i);
      chk({15'(irq_cnt - c0), lad}, 16'h0, "no conversion");
    end
  endtask

  task automatic t_standby();
    int c0;
    bus(1, A2, 8'h1C);
    bus(1, A1, 8'h21);
    bus(1, A1, 8'hA1);
    repeat (50) @(posedge clk_i);
    stby <= 1'b1;
    c0 = irq_cnt;
    bus(1, A1, 8'h43);
    bus(1, A2, 8'h30);
    bus(0, A1, 8'h00); chk(q, 8'h10, "ctrl one standby");
    bus(0, A2, 8'h00); chk(q & 8'h3F, 8'h10, "ctrl two standby");
    bus(0, AL, 8'h00); chk(q & 8'hF0, 8'h00, "low standby");
    bus(0, AH, 8'h00); chk(q, 8'h00, "high standby");
    stby <= 1'b0;
    repeat (100) @(posedge clk_i);
    chk({13'(irq_cnt - c0), lad, aie, chv}, 16'h1, "standby stop");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    for (int i = 0; i < 8; i++) t_conv(i);
    t_ladder();
    t_repeat();
    t_modes();
    t_standby();
    end_of_test();
  end

  // hang guard: the run needs about 3300 cycles
  initial begin
    #100000;
    bad_count++;
    $display("CHECK FAILED t=%0t timeout", $time);
    end_of_test();
  end
endmodule

//--- design/sarc_engine.sv
// successive approximation sequencer with conversion timer
`timescale 1ns/10ps
module sarc_engine #(
  parameter int RES_W = sarc_pkg::RES_W,
  parameter int CNT_W = sarc_pkg::CNT_W,
  parameter int BIT_W = sarc_pkg::BIT_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic             abort_i,
  input  wire logic [CNT_W-1:0] total_i,
  input  wire logic [CNT_W-1:0] slot_i,
  input  wire logic             comp_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  sample_o,
  output logic [RES_W-1:0]      code_o,
  output logic [RES_W-1:0]      result_o
);

  typedef enum {ENG_IDLE, ENG_RUN} sarc_eng_e;

  sarc_eng_e        state_ff, nxt_state;
  logic [CNT_W-1:0] tot_ff, nxt_tot;
  logic [CNT_W-1:0] sl_ff, nxt_sl;
  logic [BIT_W-1:0] bit_ff, nxt_bit;
  logic [RES_W-1:0] code_ff, nxt_code;
  logic [RES_W-1:0] result_ff, nxt_result;
  logic             done_ff, nxt_done;
  logic [RES_W-1:0] decided;

  // one-hot weight of a result bit
  function automatic logic [RES_W-1:0] bit_mask(input logic [BIT_W-1:0] b);
    bit_mask = RES_W'(1) << b;
  endfunction

  // sampling length is whatever the bit slots leave of the conversion
  wire [CNT_W-1:0] sample_len = total_i - CNT_W'(RES_W) * slot_i;
  wire             slot_end = (sl_ff == '0);
  wire             time_up = (tot_ff == '0);
  wire             sampling = (bit_ff == BIT_W'(RES_W));

  // comparator high keeps the trial bit
  assign decided = comp_i ? code_ff : (code_ff & ~bit_mask(bit_ff));

  // sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_tot = tot_ff;
    nxt_sl = sl_ff;
    nxt_bit = bit_ff;
    nxt_code = code_ff;
    nxt_result = result_ff;
    nxt_done = 1'b0;
    case (state_ff)
      ENG_IDLE: begin
        if (start_i) begin
          nxt_state = ENG_RUN;
          nxt_tot = total_i - CNT_W'(1);
          nxt_sl = sample_len - CNT_W'(1);
          nxt_bit = BIT_W'(RES_W);
          nxt_code = '0;
        end
      end
      ENG_RUN: begin
        nxt_tot = tot_ff - CNT_W'(1);
        nxt_sl = sl_ff - CNT_W'(1);
        if (abort_i) begin
          nxt_state = ENG_IDLE;
          nxt_code = '0;
        end else if (time_up) begin
          nxt_state = ENG_IDLE;
          nxt_result = decided;
          nxt_done = 1'b1;
          nxt_code = '0;
        end else if (slot_end) begin
          nxt_sl = slot_i - CNT_W'(1);
          nxt_bit = bit_ff - BIT_W'(1);
          if (sampling) begin
            nxt_code = bit_mask(BIT_W'(RES_W - 1));
          end else begin
            nxt_code = decided | bit_mask(bit_ff - BIT_W'(1));
          end
        end
      end
      default: nxt_state = ENG_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ENG_IDLE;
      tot_ff <= '0;
      sl_ff <= '0;
      bit_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      tot_ff <= nxt_tot;
      sl_ff <= nxt_sl;
      bit_ff <= nxt_bit;
    end
  end

  // data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_ff <= '0;
      result_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      result_ff <= nxt_result;
      done_ff <= nxt_done;
    end
  end

  assign busy_o = (state_ff == ENG_RUN);
  assign sample_o = busy_o & sampling;
  assign done_o = done_ff;
  assign code_o = code_ff;
  assign result_o = result_ff;

endmodule

//--- design/sarc_pkg.sv
// shared constants, register layouts and timing table for the converter control block
package sarc_pkg;

  // widths
  localparam int RES_W = 10;
  localparam int CNT_W = 11;
  localparam int REG_W = 8;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WB_SW = 4;
  localparam int BIT_W = 4;

  // register indices; byte address is four times the index
  localparam logic [WB_AW-1:0] IDX_RESULT_LOW = 8'h1F;
  localparam logic [WB_AW-1:0] IDX_RESULT_HIGH = 8'h20;
  localparam logic [WB_AW-1:0] IDX_CTRL_ONE = 8'h25;
  localparam logic [WB_AW-1:0] IDX_CTRL_TWO = 8'h26;
  localparam int ADR_STRIDE = 4;
  localparam logic [WB_AW-1:0] ADR_RESULT_LOW = WB_AW'(IDX_RESULT_LOW * ADR_STRIDE);
  localparam logic [WB_AW-1:0] ADR_RESULT_HIGH = WB_AW'(IDX_RESULT_HIGH * ADR_STRIDE);
  localparam logic [WB_AW-1:0] ADR_CTRL_ONE = WB_AW'(IDX_CTRL_ONE * ADR_STRIDE);
  localparam logic [WB_AW-1:0] ADR_CTRL_TWO = WB_AW'(IDX_CTRL_TWO * ADR_STRIDE);

  // operating mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // channel select: codes up to this one name a real input
  localparam logic [3:0] CHAN_LAST = 4'h7;

  // reset values
  localparam logic [REG_W-1:0] CTRL_ONE_RESET = 8'h10;
  localparam logic [REG_W-1:0] CTRL_TWO_RESET = 8'h10;
  localparam logic [REG_W-1:0] RESULT_HIGH_RESET = 8'h00;

  // conversion time codes and lengths in fc cycles
  localparam logic [2:0] TIME_39 = 3'h0;
  localparam logic [2:0] TIME_78 = 3'h2;
  localparam logic [2:0] TIME_156 = 3'h3;
  localparam logic [2:0] TIME_312 = 3'h4;
  localparam logic [2:0] TIME_624 = 3'h5;
  localparam logic [2:0] TIME_1248 = 3'h6;
  localparam int CONV_39 = 39;
  localparam int CONV_78 = 78;
  localparam int CONV_156 = 156;
  localparam int CONV_312 = 312;
  localparam int CONV_624 = 624;
  localparam int CONV_1248 = 1248;
  // one bit decision takes a twelfth of the conversion, the rest is sampling
  localparam int SLOT_DIV = 12;

  // control register one layout
  typedef struct packed {
    logic       start;
    logic [1:0] mode;
    logic       ain_disable;
    logic [3:0] chan;
  } sarc_ctrl_one_s;

  // control register two layout
  typedef struct packed {
    logic [1:0] undef;
    logic       ladder_always;
    logic       fixed_one;
    logic [2:0] time_code;
    logic       fixed_zero;
  } sarc_ctrl_two_s;

  // lower result register layout
  typedef struct packed {
    logic [1:0] res_lo;
    logic       eoc;
    logic       busy;
    logic [3:0] unstable;
  } sarc_low_s;

  // conversion timing pair
  typedef struct packed {
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] slot;
  } sarc_timing_s;

  // time code to total and per-bit cycle counts; reserved codes act as the shortest
  function automatic sarc_timing_s conv_timing(input logic [2:0] code);
    int n;
    n = CONV_39;
    case (code)
      TIME_78:   n = CONV_78;
      TIME_156:  n = CONV_156;
      TIME_312:  n = CONV_312;
      TIME_624:  n = CONV_624;
      TIME_1248: n = CONV_1248;
      default:   n = CONV_39;
    endcase
    conv_timing.total = CNT_W'(n);
    conv_timing.slot = CNT_W'(n / SLOT_DIV);
  endfunction

endpackage

//--- design/sarc_regs.sv
// converter control and status registers with classic wishbone slave
`timescale 1ns/10ps
// Operation
// - start bit launches conversion, then self-clears
// - mode 00 off, 01 single, 11 repeat
// - input control bit one disables analog inputs
// - channel codes 0 to 7 select inputs
// - standby resets controls and blocks their writes
// - ladder connected during conversion or always
// - time field sets conversion length in cycles
// - control two bits 7 and 6 undefined
// - end flag zero until conversion completes
// - reading high result clears end flag
// - busy flag follows conversion, cleared in standby
// - low result bits 3 to 0 ignored
// - completion stores result, flag, interrupt together
// - repeat mode restarts on each completion
// - mode 00 aborts repeat, no store
module sarc_regs #(
  parameter int RES_W = sarc_pkg::RES_W,
  parameter int CNT_W = sarc_pkg::CNT_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [sarc_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [sarc_pkg::WB_SW-1:0] wb_sel_i,
  input  wire logic [sarc_pkg::WB_DW-1:0] wb_dat_i,
  output logic [sarc_pkg::WB_DW-1:0]      wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       standby_i,
  input  wire logic                       comp_i,
  output logic [2:0]                      channel_o,
  output logic                            channel_valid_o,
  output logic                            analog_input_enable_o,
  output logic                            ladder_connect_o,
  output logic                            sample_o,
  output logic [RES_W-1:0]                dac_code_o,
  output logic                            conversion_done_interrupt_o
);

  localparam int REG_W = sarc_pkg::REG_W;
  localparam int WB_DW = sarc_pkg::WB_DW;

  sarc_pkg::sarc_ctrl_one_s ctrl_one_ff, nxt_ctrl_one;
  sarc_pkg::sarc_ctrl_two_s ctrl_two_ff, nxt_ctrl_two;
  sarc_pkg::sarc_low_s      low_view;
  sarc_pkg::sarc_timing_s   timing;

  logic [RES_W-1:0] result_ff, nxt_result;
  logic             eoc_ff, nxt_eoc;
  logic             ack_ff;
  logic [WB_DW-1:0] rdata_ff;
  logic             comp_meta_ff;
  logic             comp_sync_ff;
  logic             irq_ff;
  logic             eng_busy;
  logic             eng_done;
  logic             eng_sample;
  logic [RES_W-1:0] eng_code;
  logic [RES_W-1:0] eng_result;
  logic [REG_W-1:0] rd_byte;

  // bus request decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_fire = bus_req & ack_ff;
  wire lane0 = wb_sel_i[0];
  wire hit_low = (wb_adr_i == sarc_pkg::ADR_RESULT_LOW);
  wire hit_high = (wb_adr_i == sarc_pkg::ADR_RESULT_HIGH);
  wire hit_one = (wb_adr_i == sarc_pkg::ADR_CTRL_ONE);
  wire hit_two = (wb_adr_i == sarc_pkg::ADR_CTRL_TWO);

  // writes land at the edge where ack is seen; standby locks them out
  wire wr_ok = bus_fire & wb_we_i & lane0 & ~standby_i;
  wire wr_one = wr_ok & hit_one;
  wire wr_two = wr_ok & hit_two;
  wire rd_high = bus_fire & ~wb_we_i & hit_high;

  // incoming write byte seen through the register layouts
  wire [REG_W-1:0] wr_byte = wb_dat_i[REG_W-1:0];
  sarc_pkg::sarc_ctrl_one_s wr_one_val;
  sarc_pkg::sarc_ctrl_two_s wr_two_val;
  assign wr_one_val = sarc_pkg::sarc_ctrl_one_s'(wr_byte);
  assign wr_two_val = sarc_pkg::sarc_ctrl_two_s'(wr_byte);

  // mode decode
  wire mode_single = (ctrl_one_ff.mode == sarc_pkg::MODE_SINGLE);
  wire mode_repeat = (ctrl_one_ff.mode == sarc_pkg::MODE_REPEAT);
  wire mode_off = (ctrl_one_ff.mode == sarc_pkg::MODE_OFF);
  wire mode_run = mode_single | mode_repeat;

  // conversion launch, repeat restart and abort
  wire launch = ctrl_one_ff.start & mode_run & ~eng_busy & ~standby_i;
  wire restart = eng_done & mode_repeat & ~standby_i;
  wire eng_start = launch | restart;
  wire eng_abort = eng_busy & (mode_off | standby_i);

  // conversion length from the time field
  assign timing = sarc_pkg::conv_timing(ctrl_two_ff.time_code);

  // comparator crosses in from the analog side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else begin
      comp_meta_ff <= comp_i;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  // bit sequencer and conversion timer
  sarc_engine #(
    .RES_W (RES_W),
    .CNT_W (CNT_W)
  ) u_engine (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (eng_start),
    .abort_i  (eng_abort),
    .total_i  (timing.total),
    .slot_i   (timing.slot),
    .comp_i   (comp_sync_ff),
    .busy_o   (eng_busy),
    .done_o   (eng_done),
    .sample_o (eng_sample),
    .code_o   (eng_code),
    .result_o (eng_result)
  );

  // control register one: standby reset, write, then start self-clear
  always_comb begin
    nxt_ctrl_one = ctrl_one_ff;
    if (standby_i) begin
      nxt_ctrl_one = sarc_pkg::sarc_ctrl_one_s'(sarc_pkg::CTRL_ONE_RESET);
    end else if (wr_one) begin
      nxt_ctrl_one = wr_one_val;
    end else if (launch) begin
      nxt_ctrl_one.start = 1'b0;
    end
  end

  // control register two: standby reset or write
  always_comb begin
    nxt_ctrl_two = ctrl_two_ff;
    if (standby_i) begin
      nxt_ctrl_two = sarc_pkg::sarc_ctrl_two_s'(sarc_pkg::CTRL_TWO_RESET);
    end else if (wr_two) begin
      nxt_ctrl_two = wr_two_val;
      nxt_ctrl_two.undef = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_ff <= sarc_pkg::sarc_ctrl_one_s'(sarc_pkg::CTRL_ONE_RESET);
      ctrl_two_ff <= sarc_pkg::sarc_ctrl_two_s'(sarc_pkg::CTRL_TWO_RESET);
    end else begin
      ctrl_one_ff <= nxt_ctrl_one;
      ctrl_two_ff <= nxt_ctrl_two;
    end
  end

  // result store; standby discards earlier results
  always_comb begin
    nxt_result = result_ff;
    if (standby_i) begin
      nxt_result = '0;
    end else if (eng_done) begin
      nxt_result = eng_result;
    end
  end

  // end flag: completion wins over the read clear and the new start
  always_comb begin
    nxt_eoc = eoc_ff;
    if (standby_i) begin
      nxt_eoc = 1'b0;
    end else if (eng_done) begin
      nxt_eoc = 1'b1;
    end else if (launch) begin
      nxt_eoc = 1'b0;
    end else if (rd_high) begin
      nxt_eoc = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_ff <= '0;
      eoc_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      eoc_ff <= nxt_eoc;
    end
  end

  // completion pulse toward the interrupt controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= eng_done & ~standby_i;
    end
  end

  // lower result view: two low bits, end flag, busy, unstable nibble as zero
  assign low_view.res_lo = result_ff[1:0];
  assign low_view.eoc = eoc_ff;
  assign low_view.busy = eng_busy;
  assign low_view.unstable = '0;

  // read select; bits 7 and 6 of control two read as zero
  assign rd_byte = hit_low  ? REG_W'(low_view) :
                   hit_high ? result_ff[RES_W-1:RES_W-REG_W] :
                   hit_one  ? REG_W'(ctrl_one_ff) :
                   hit_two  ? REG_W'(ctrl_two_ff) :
                   '0;

  // single wait state acknowledge with registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (bus_req & ~ack_ff) begin
      rdata_ff <= WB_DW'(rd_byte);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // analog side controls
  assign channel_valid_o = (ctrl_one_ff.chan <= sarc_pkg::CHAN_LAST);
  assign channel_o = ctrl_one_ff.chan[2:0];
  assign analog_input_enable_o = ~ctrl_one_ff.ain_disable;
  assign ladder_connect_o = ctrl_two_ff.ladder_always | eng_busy;
  assign sample_o = eng_sample;
  assign dac_code_o = eng_code;
  assign conversion_done_interrupt_o = irq_ff;

endmodule
